/* mmu_pkg.sv */
/*
  Shared constants and types for the retention-memory protection units and
  the code/data RAM page-mapping units.
  Assumes a 32-bit address space and a 3-bit process identifier.
*/
package mmu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (APB byte addresses)
  localparam logic [7:0] ADDR_FAST_PERMIT = 8'h00;
  localparam logic [7:0] ADDR_SLOW_PERMIT = 8'h04;
  localparam logic [7:0] ADDR_CODE_SIZE = 8'h08;
  localparam logic [7:0] ADDR_DATA_SIZE = 8'h0C;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] ADDR_CODE_ENTRY = 8'h40;
  localparam logic [7:0] ADDR_DATA_ENTRY = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Memory map
  localparam logic [31:0] CODE_BASE = 32'h4008_0000;
  localparam logic [31:0] DATA_BASE = 32'h3FFC_0000;
  localparam logic [31:0] FAST_BASE_LO = 32'h3FF8_0000;
  localparam logic [31:0] FAST_BASE_HI = 32'h400C_0000;
  localparam logic [31:0] SLOW_BASE = 32'h5000_0000;
  localparam int REGION_BITS = 17;
  localparam int RETENTION_BITS = 13;
  localparam int PAGE_COUNT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Page sizes and entry fields
  localparam logic [1:0] PAGE_8K = 2'h0;
  localparam logic [1:0] PAGE_4K = 2'h1;
  localparam logic [1:0] PAGE_2K = 2'h2;
  localparam logic [2:0] RIGHTS_NONE = 3'h0;
  localparam logic [2:0] RIGHTS_ALL = 3'h1;
  localparam logic [2:0] LAST_PRIV_ID = 3'h1;
  localparam logic [2:0] SLOW_FIELD_SHIFT = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] FAST_PERMIT_RESET = 8'h00;
  localparam logic [5:0] SLOW_PERMIT_RESET = 6'h00;
  localparam logic [1:0] PAGE_SIZE_RESET = 2'h0;
  localparam logic [6:0] ENTRY_RESET = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [2:0] process_identifier_type;

  typedef struct packed {
    logic [2:0] rights;
    logic [3:0] vpage;
  } entry_type;

  typedef struct packed {
    logic valid;
    logic write;
    process_identifier_type process_identifier;
    logic [31:0] addr;
  } mem_req_type;

  typedef struct packed {
    logic en;
    logic we;
    logic fault;
    logic [31:0] addr;
  } mem_rsp_type;

endpackage : mmu_pkg

/* retention_guard.sv */
/*
  Permit check for one retention memory.
  Assumes the caller has decoded the address range and aligned the permit
  field so that bit n belongs to process identifier n.
*/
`timescale 1ns/1ps
`default_nettype none

module retention_guard
  import mmu_pkg::*;
#(
  parameter bit FIXED_PRIV = 1'b0
) (
  input wire logic in_range,
  input wire process_identifier_type process_identifier,
  input wire logic [7:0] permit,
  output logic granted
);

  ////////////////////////////////////////////////////////////////////////////
  // Set bit admits, clear bit refuses unless FIXED_PRIV and identifier at most LAST_PRIV_ID
  always_comb begin
    granted = in_range && (permit[process_identifier] || // [RULE_02]
      (FIXED_PRIV && process_identifier <= LAST_PRIV_ID)); // [RULE_03]
  end

endmodule : retention_guard

`default_nettype wire

/* page_unit.sv */
/*
  Page lookup and translation for one 128 KB region.
  Assumes the offset is already known to lie inside the region.
*/
`timescale 1ns/1ps
`default_nettype none

module page_unit
  import mmu_pkg::*;
#(
  parameter int PAGES = PAGE_COUNT
) (
  input wire logic [REGION_BITS-1:0] offset,
  input wire logic [1:0] page_size,
  input wire process_identifier_type process_identifier,
  input wire entry_type entries [PAGES],
  output logic granted,
  output logic [REGION_BITS-1:0] phys_offset
);

  logic mapped;
  logic priv;
  logic found;
  logic [3:0] vpage;
  logic [3:0] ppage;

  always_comb begin
    priv = process_identifier <= LAST_PRIV_ID;
    // Page number field per size; above page 15 is unmapped
    case (page_size)
      PAGE_8K: begin // [RULE_09] [RULE_08]
        mapped = 1'b1;
        vpage = offset[16:13];
      end
      PAGE_4K: begin // [RULE_12] [RULE_13]
        mapped = !offset[16];
        vpage = offset[15:12];
      end
      PAGE_2K: begin // [RULE_12]
        mapped = offset[16:15] == 2'h0;
        vpage = offset[14:11];
      end
      default: begin
        mapped = 1'b0;
        vpage = 4'h0;
      end
    endcase
    // Physical page whose entry names this virtual page and admits caller
    found = 1'b0;
    ppage = 4'h0;
    for (int i = 0; i < PAGES; i++) begin // [RULE_16]
      if (!found && entries[i].vpage == vpage && entries[i].rights != RIGHTS_NONE &&
          (entries[i].rights == RIGHTS_ALL || entries[i].rights == process_identifier)) begin
        found = 1'b1;
        ppage = 4'(i);
      end
    end
    granted = priv || (mapped && found); // [RULE_14] [RULE_07]
    // Identity for privileged callers, page swap keeps in-page offset
    phys_offset = offset; // [RULE_10] [RULE_15]
    if (!priv && mapped) begin // [RULE_11]
      case (page_size)
        PAGE_8K: phys_offset[16:13] = ppage;
        PAGE_4K: phys_offset[15:12] = ppage;
        PAGE_2K: phys_offset[14:11] = ppage;
        default: phys_offset = offset;
      endcase
    end
  end

endmodule : page_unit

`default_nettype wire

/* sram_page_mmu_rtc_mpu.sv */
/*
  Access checks and address translation for on-chip RAM: two retention
  memory protection units and two page-mapping units, APB configured.
  Assumes the bus master supplies the process identifier of the running
  code with each APB transfer and each memory request; single clock.
*/
// Decided for this implementation: the APB slave port and the register offsets.
// Contract
// (RULE_01) Two protection units guard fast, slow retention
// (RULE_02) Set bit admits process, clear bit refuses
// (RULE_03) Identifiers 0 and 1 always reach slow
// (RULE_04) Fast field per id; slow bits for 2..7
// (RULE_05) Fast permit written only by identifier 0
// (RULE_06) Slow permit written only by identifiers 0,1
// (RULE_07) Code and data upper 128 KB page-mapped
// (RULE_08) Sixteen pages per region, any size
// (RULE_09) Size 0,1,2 selects 8,4,2 KB pages
// (RULE_10) Identifiers 0,1 get identity page mapping
// (RULE_11) Others remapped per process, offset kept
// (RULE_12) 4 KB leaves 64 KB, 2 KB 96 KB unmapped
// (RULE_13) Code unmapped span starts 40090000 at 4 KB
// (RULE_14) Unmapped memory only for identifiers 0,1
// (RULE_15) Pages laid out linearly from region base
// (RULE_16) Entry: rights in 6:4, virtual page 3:0
// (RULE_17) Entries and sizes written only by 0,1
// (RULE_18) Refused access never touches memory data
`timescale 1ns/1ps
`default_nettype none

module sram_page_mmu_rtc_mpu
  import mmu_pkg::*;
#(
  parameter int PAGES = PAGE_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire process_identifier_type bus_process_identifier,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mem_req_type code_req,
  input wire mem_req_type data_req,
  input wire mem_req_type fast_req,
  input wire mem_req_type slow_req,
  output mem_rsp_type code_rsp,
  output mem_rsp_type data_rsp,
  output mem_rsp_type fast_rsp,
  output mem_rsp_type slow_rsp
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] fast_retention_permit_q, fast_retention_permit_d;
  logic [5:0] slow_retention_permit_q, slow_retention_permit_d;
  logic [1:0] code_ram_page_size_q, code_ram_page_size_d;
  logic [1:0] data_ram_page_size_q, data_ram_page_size_d;
  entry_type code_ram_page_entry_q [PAGES];
  entry_type code_ram_page_entry_d [PAGES];
  entry_type data_ram_page_entry_q [PAGES];
  entry_type data_ram_page_entry_d [PAGES];
  logic [3:0] fault_q, fault_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  mem_rsp_type code_rsp_q, code_rsp_d;
  mem_rsp_type data_rsp_q, data_rsp_d;
  mem_rsp_type fast_rsp_q, fast_rsp_d;
  mem_rsp_type slow_rsp_q, slow_rsp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Range decode
  logic code_in, data_in, fast_in, slow_in;
  logic code_ok, data_ok, fast_ok, slow_ok;
  logic [REGION_BITS-1:0] code_phys, data_phys;

  always_comb begin
    code_in = code_req.addr[31:REGION_BITS] == CODE_BASE[31:REGION_BITS]; // [RULE_07]
    data_in = data_req.addr[31:REGION_BITS] == DATA_BASE[31:REGION_BITS];
    // Both aliases share one permit field
    fast_in = fast_req.addr[31:RETENTION_BITS] == FAST_BASE_LO[31:RETENTION_BITS] || // [RULE_04]
      fast_req.addr[31:RETENTION_BITS] == FAST_BASE_HI[31:RETENTION_BITS];
    slow_in = slow_req.addr[31:RETENTION_BITS] == SLOW_BASE[31:RETENTION_BITS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checkers
  retention_guard #(.FIXED_PRIV(1'b0)) u_fast_guard ( // [RULE_01]
    .in_range(fast_in),
    .process_identifier(fast_req.process_identifier),
    .permit(fast_retention_permit_q),
    .granted(fast_ok)
  );

  retention_guard #(.FIXED_PRIV(1'b1)) u_slow_guard ( // [RULE_01]
    .in_range(slow_in),
    .process_identifier(slow_req.process_identifier),
    .permit({slow_retention_permit_q, 2'b00}), // [RULE_04]
    .granted(slow_ok)
  );

  logic code_hit, data_hit;

  page_unit #(.PAGES(PAGES)) u_code_pages (
    .offset(code_req.addr[REGION_BITS-1:0]),
    .page_size(code_ram_page_size_q),
    .process_identifier(code_req.process_identifier),
    .entries(code_ram_page_entry_q),
    .granted(code_hit),
    .phys_offset(code_phys)
  );

  page_unit #(.PAGES(PAGES)) u_data_pages (
    .offset(data_req.addr[REGION_BITS-1:0]),
    .page_size(data_ram_page_size_q),
    .process_identifier(data_req.process_identifier),
    .entries(data_ram_page_entry_q),
    .granted(data_hit),
    .phys_offset(data_phys)
  );

  assign code_ok = code_in && code_hit;
  assign data_ok = data_in && data_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Memory strobes only on grant
  function automatic mem_rsp_type build_rsp(mem_req_type req, logic ok, logic [31:0] addr);
    mem_rsp_type r;
    r.en = req.valid && ok; // [RULE_18]
    r.we = req.valid && req.write && ok; // [RULE_18]
    r.fault = req.valid && !ok;
    r.addr = ok ? addr : 32'h0000_0000;
    return r;
  endfunction : build_rsp

  always_comb begin
    code_rsp_d = build_rsp(code_req, code_ok, {code_req.addr[31:REGION_BITS], code_phys});
    data_rsp_d = build_rsp(data_req, data_ok, {data_req.addr[31:REGION_BITS], data_phys});
    fast_rsp_d = build_rsp(fast_req, fast_ok, fast_req.addr);
    slow_rsp_d = build_rsp(slow_req, slow_ok, slow_req.addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file
  logic setup, wr, code_sel, data_sel, hit, bus_priv, bus_root;
  logic [3:0] idx;
  logic [3:0] fault_set;
  logic [31:0] rd;

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pready_q && pwrite && !pslverr_q;
    idx = paddr[5:2];
    code_sel = paddr[7:6] == ADDR_CODE_ENTRY[7:6] && paddr[1:0] == 2'h0;
    data_sel = paddr[7:6] == ADDR_DATA_ENTRY[7:6] && paddr[1:0] == 2'h0;
    bus_priv = bus_process_identifier <= LAST_PRIV_ID;
    bus_root = bus_process_identifier == 3'h0;
    fault_set = {slow_rsp_d.fault, fast_rsp_d.fault, data_rsp_d.fault, code_rsp_d.fault};
    fast_retention_permit_d = fast_retention_permit_q;
    slow_retention_permit_d = slow_retention_permit_q;
    code_ram_page_size_d = code_ram_page_size_q;
    data_ram_page_size_d = data_ram_page_size_q;
    code_ram_page_entry_d = code_ram_page_entry_q;
    data_ram_page_entry_d = data_ram_page_entry_q;
    fault_d = fault_q | fault_set;
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (paddr)
      ADDR_FAST_PERMIT: rd = 32'(fast_retention_permit_q);
      ADDR_SLOW_PERMIT: rd = 32'(slow_retention_permit_q);
      ADDR_CODE_SIZE: rd = 32'(code_ram_page_size_q);
      ADDR_DATA_SIZE: rd = 32'(data_ram_page_size_q);
      ADDR_FAULT: rd = 32'(fault_q);
      default: begin
        if (code_sel) begin
          rd = 32'(code_ram_page_entry_q[idx]);
        end else if (data_sel) begin
          rd = 32'(data_ram_page_entry_q[idx]);
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    if (wr) begin
      case (paddr)
        ADDR_FAST_PERMIT: begin
          if (bus_root) begin // [RULE_05]
            fast_retention_permit_d = pwdata[7:0];
          end
        end
        ADDR_SLOW_PERMIT: begin
          if (bus_priv) begin // [RULE_06]
            slow_retention_permit_d = pwdata[5:0];
          end
        end
        ADDR_CODE_SIZE: begin
          if (bus_priv) begin // [RULE_17]
            code_ram_page_size_d = pwdata[1:0];
          end
        end
        ADDR_DATA_SIZE: begin
          if (bus_priv) begin // [RULE_17]
            data_ram_page_size_d = pwdata[1:0];
          end
        end
        ADDR_FAULT: fault_d = (fault_q & ~pwdata[3:0]) | fault_set;
        default: begin
          if (bus_priv && code_sel) begin // [RULE_17]
            code_ram_page_entry_d[idx] = entry_type'(pwdata[6:0]); // [RULE_16]
          end
          if (bus_priv && data_sel) begin // [RULE_17]
            data_ram_page_entry_d[idx] = entry_type'(pwdata[6:0]);
          end
        end
      endcase
    end
    pready_d = setup;
    pslverr_d = setup && !hit;
    prdata_d = (setup && !pwrite && hit) ? rd : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_retention_permit_q <= FAST_PERMIT_RESET;
      slow_retention_permit_q <= SLOW_PERMIT_RESET;
      code_ram_page_size_q <= PAGE_SIZE_RESET;
      data_ram_page_size_q <= PAGE_SIZE_RESET;
      for (int i = 0; i < PAGES; i++) begin
        code_ram_page_entry_q[i] <= entry_type'(ENTRY_RESET);
        data_ram_page_entry_q[i] <= entry_type'(ENTRY_RESET);
      end
      fault_q <= 4'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      code_rsp_q <= '0;
      data_rsp_q <= '0;
      fast_rsp_q <= '0;
      slow_rsp_q <= '0;
    end else begin
      fast_retention_permit_q <= fast_retention_permit_d;
      slow_retention_permit_q <= slow_retention_permit_d;
      code_ram_page_size_q <= code_ram_page_size_d;
      data_ram_page_size_q <= data_ram_page_size_d;
      code_ram_page_entry_q <= code_ram_page_entry_d;
      data_ram_page_entry_q <= data_ram_page_entry_d;
      fault_q <= fault_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      code_rsp_q <= code_rsp_d;
      data_rsp_q <= data_rsp_d;
      fast_rsp_q <= fast_rsp_d;
      slow_rsp_q <= slow_rsp_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign code_rsp = code_rsp_q;
  assign data_rsp = data_rsp_q;
  assign fast_rsp = fast_rsp_q;
  assign slow_rsp = slow_rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fast_write_root;
    wr && paddr == ADDR_FAST_PERMIT && bus_process_identifier != 3'h0
      |=> $stable(fast_retention_permit_q);
  endproperty
  a_fast_write_root: assert property (p_fast_write_root) // [RULE_05]
    else $error("fast permit changed by non-root");

  property p_slow_write_priv;
    psel && penable && pready && pwrite && paddr == ADDR_SLOW_PERMIT &&
      bus_process_identifier > 3'h1 |=> $stable(slow_retention_permit_q);
  endproperty
  a_slow_write_priv: assert property (p_slow_write_priv) // [RULE_06]
    else $error("slow permit changed by unprivileged");

  property p_size_write_priv;
    psel && penable && pready && pwrite && paddr == ADDR_CODE_SIZE &&
      bus_process_identifier > 3'h1 |=> $stable(code_ram_page_size_q);
  endproperty
  a_size_write_priv: assert property (p_size_write_priv) // [RULE_17]
    else $error("page size changed by unprivileged");

  property p_slow_priv_access;
    slow_req.valid && slow_in && slow_req.process_identifier <= 3'h1 |=> slow_rsp.en && !slow_rsp.fault;
  endproperty
  a_slow_priv_access: assert property (p_slow_priv_access) // [RULE_03]
    else $error("privileged slow access refused");

  property p_fast_refuse;
    fast_req.valid && !fast_retention_permit_q[fast_req.process_identifier]
      |=> fast_rsp.fault && !fast_rsp.en;
  endproperty
  a_fast_refuse: assert property (p_fast_refuse) // [RULE_02]
    else $error("fast access without permit bit");

  property p_code_identity;
    code_req.valid && code_in && code_req.process_identifier <= 3'h1
      |=> code_rsp.en && code_rsp.addr == $past(code_req.addr);
  endproperty
  a_code_identity: assert property (p_code_identity) // [RULE_10]
    else $error("privileged code address altered");

  property p_unmapped_refuse;
    data_req.valid && data_in && data_req.process_identifier > 3'h1 &&
      data_ram_page_size_q == PAGE_4K && data_req.addr[16] |=> data_rsp.fault;
  endproperty
  a_unmapped_refuse: assert property (p_unmapped_refuse) // [RULE_14]
    else $error("unmapped data access granted");

  property p_offset_kept;
    code_rsp_d.en |=> code_rsp.addr[10:0] == $past(code_req.addr[10:0]);
  endproperty
  a_offset_kept: assert property (p_offset_kept) // [RULE_11]
    else $error("in-page offset changed");

  property p_no_strobe_on_fault;
    !(code_rsp.fault && (code_rsp.en || code_rsp.we)) && !(data_rsp.fault && (data_rsp.en || data_rsp.we));
  endproperty
  a_no_strobe_on_fault: assert property (p_no_strobe_on_fault) // [RULE_18]
    else $error("memory strobed on refused access");

endmodule : sram_page_mmu_rtc_mpu

`default_nettype wire

/* cpu_bus_model.sv */
/*
  CPU side model: drives the code, data, fast and slow request channels.
  Assumes a rising-edge pclk shared with the device.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model
  import mmu_pkg::*;
(
  input wire logic pclk,
  output mem_req_type req [4]
);
  initial begin
    for (int i = 0; i < 4; i++) begin
      req[i] = '0;
    end
  end

  // One request for one cycle, then the channel shows inverted junk
  task automatic issue(input int ch, input logic wr, input process_identifier_type id, input logic [31:0] a);
    @(posedge pclk);
    req[ch] <= '{valid: 1'b1, write: wr, process_identifier: id, addr: a};
    @(posedge pclk);
    req[ch] <= '{valid: 1'b0, write: ~wr, process_identifier: ~id, addr: ~a};
  endtask : issue
endmodule : cpu_bus_model

`default_nettype wire

/* sram_page_mmu_rtc_mpu_tb.sv */
/*
  Self-checking bench: APB register access and memory channel checks.
  Assumes the CPU bus model drives the four request channels.
*/
`timescale 1ns/1ps
`default_nettype none

module sram_page_mmu_rtc_mpu_tb
  import mmu_pkg::*;
;
  localparam logic [7:0] FAST_OK = 8'hA5;
  localparam logic [7:0] SLOW_OK = 8'h17;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  process_identifier_type bus_process_identifier;
  mem_req_type req [4];
  mem_rsp_type rsp [4];
  int n_errors = 0;
  int checks_done = 0;

  always #2.5 pclk = ~pclk;

  sram_page_mmu_rtc_mpu #(.PAGES(PAGE_COUNT)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .bus_process_identifier(bus_process_identifier),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_req(req[0]), .data_req(req[1]), .fast_req(req[2]), .slow_req(req[3]),
    .code_rsp(rsp[0]), .data_rsp(rsp[1]), .fast_rsp(rsp[2]), .slow_rsp(rsp[3])
  );

  cpu_bus_model u_cpu (.pclk(pclk), .req(req));

  //////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input process_identifier_type id);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    bus_process_identifier <= id;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 3'h0);
    chk({er, rd}, {1'b0, exp});
  endtask : rchk

  task automatic mchk(input int ch, input logic wr, input process_identifier_type id, input logic [31:0] a,
                      input logic ok, input logic [31:0] pa);
    u_cpu.issue(ch, wr, id, a);
    #1;
    chk(rsp[ch], ok ? {ok, wr, 1'b0, pa} : {3'b001, 32'h0});
  endtask : mchk

  //////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] regs [7];
    regs = '{ADDR_FAST_PERMIT, ADDR_SLOW_PERMIT, ADDR_CODE_SIZE, ADDR_DATA_SIZE, ADDR_FAULT, ADDR_CODE_ENTRY,
             ADDR_DATA_ENTRY};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_process_identifier = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rchk(regs[i], 32'h0);
    end
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, 3'h0);
    chk(er, 1'b1);
    // Permit writers by identifier
    apb(1'b1, ADDR_FAST_PERMIT, 32'hFF, 3'h1);
    rchk(ADDR_FAST_PERMIT, 32'h0);
    apb(1'b1, ADDR_FAST_PERMIT, 32'h1A5, 3'h0);
    rchk(ADDR_FAST_PERMIT, 32'hA5);
    apb(1'b1, ADDR_SLOW_PERMIT, 32'h3F, 3'h2);
    rchk(ADDR_SLOW_PERMIT, 32'h0);
    apb(1'b1, ADDR_SLOW_PERMIT, 32'h05, 3'h1);
    rchk(ADDR_SLOW_PERMIT, 32'h05);
    apb(1'b1, ADDR_CODE_SIZE, 32'h1, 3'h2);
    apb(1'b1, ADDR_CODE_ENTRY + 8'h08, 32'h12, 3'h5);
    rchk(ADDR_CODE_SIZE, 32'h0);
    rchk(ADDR_CODE_ENTRY + 8'h08, 32'h0);
    // Retention memories, every identifier
    for (int i = 0; i < 8; i++) begin
      mchk(2, i[0], 3'(i), FAST_BASE_LO + 32'h10, FAST_OK[i], FAST_BASE_LO + 32'h10);
      mchk(2, 1'b1, 3'(i), FAST_BASE_HI + 32'h1FFC, FAST_OK[i], FAST_BASE_HI + 32'h1FFC);
      mchk(3, 1'b1, 3'(i), SLOW_BASE + 32'h40, SLOW_OK[i], SLOW_BASE + 32'h40);
    end
    // Code region, 8 KB pages
    apb(1'b1, ADDR_CODE_ENTRY + 8'h08, 32'h11, 3'h0);
    apb(1'b1, ADDR_CODE_ENTRY + 8'h14, 32'h43, 3'h1);
    rchk(ADDR_CODE_ENTRY + 8'h14, 32'h43);
    mchk(0, 1'b0, 3'h3, 32'h4008_2345, 1'b1, 32'h4008_4345);
    mchk(0, 1'b1, 3'h0, 32'h4008_2345, 1'b1, 32'h4008_2345);
    mchk(0, 1'b1, 3'h4, 32'h4008_6010, 1'b1, 32'h4008_A010);
    mchk(0, 1'b0, 3'h5, 32'h4008_6010, 1'b0, 32'h0);
    mchk(0, 1'b1, 3'h2, 32'h4008_0000, 1'b0, 32'h0);
    // Code region, 4 KB pages
    apb(1'b1, ADDR_CODE_SIZE, 32'h1, 3'h1);
    mchk(0, 1'b0, 3'h3, 32'h4008_1345, 1'b1, 32'h4008_2345);
    mchk(0, 1'b0, 3'h2, 32'h4009_0000, 1'b0, 32'h0);
    mchk(0, 1'b1, 3'h1, 32'h4009_FFFC, 1'b1, 32'h4009_FFFC);
    // Data region, 2 KB then 4 KB pages, last physical page
    apb(1'b1, ADDR_DATA_ENTRY + 8'h3C, 32'h10, 3'h0);
    apb(1'b1, ADDR_DATA_SIZE, 32'h2, 3'h0);
    rchk(ADDR_DATA_SIZE, 32'h2);
    mchk(1, 1'b1, 3'h6, DATA_BASE + 32'h123, 1'b1, DATA_BASE + 32'h7923);
    mchk(1, 1'b1, 3'h6, DATA_BASE + 32'h8000, 1'b0, 32'h0);
    mchk(1, 1'b1, 3'h0, DATA_BASE + 32'h8000, 1'b1, DATA_BASE + 32'h8000);
    apb(1'b1, ADDR_DATA_SIZE, 32'h1, 3'h1);
    mchk(1, 1'b0, 3'h7, DATA_BASE + 32'h123, 1'b1, DATA_BASE + 32'hF123);
    mchk(1, 1'b0, 3'h7, 32'h3FFD_0000, 1'b0, 32'h0);
    // Sticky refusal flags, write one to clear
    rchk(ADDR_FAULT, 32'hF);
    apb(1'b1, ADDR_FAULT, 32'h5, 3'h3);
    rchk(ADDR_FAULT, 32'hA);
    // Mid-run reset returns permits and sizes to defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_FAST_PERMIT, 32'h0);
    rchk(ADDR_DATA_SIZE, 32'h0);
    mchk(3, 1'b1, 3'h1, SLOW_BASE + 32'h40, 1'b1, SLOW_BASE + 32'h40);
    mchk(3, 1'b1, 3'h2, SLOW_BASE + 32'h40, 1'b0, 32'h0);
    wrap_up();
  end
endmodule : sram_page_mmu_rtc_mpu_tb

`default_nettype wire
